// ===== design/chan_cal_cfg.svh
// register offsets, field positions, reset values and codes for the channel calibration bank
// ==========================================================================
// How it works
// - offset high register holds bits 23..8 of the 24-bit signed offset correction
// - offset low register bits 15..8 hold offset correction bits 7..0, read-write
// - gain high register holds bits 23..8 of the unsigned 24-bit gain correction
// - gain low register bits 15..8 hold gain correction bits 7..0, read-write
// - gain high resets to 8000h, gain low resets to zero
// - offset high, offset low and configuration registers reset to zero
// - low byte of offset low and gain low is reserved, reads zero
// - configuration bits 15..6 hold a signed 10-bit phase delay in modulator cycles
// - configuration bits 5..3 are reserved and always read zero
// - configuration bit 2 set disables dc filtering for this channel only
// - configuration bits 1..0 select pins, shorted inputs, positive or negative test
`ifndef CHAN_CAL_CFG_SVH
`define CHAN_CAL_CFG_SVH
// ==========================================================================
// register indices, byte address is four times the index
`define IDX_CH1_OFS_LO 8'h10
`define IDX_CH1_GAIN_HI 8'h11
`define IDX_CH1_GAIN_LO 8'h12
`define IDX_CH2_CONFIG 8'h13
`define IDX_CH2_OFS_HI 8'h14
`define IDX_CH2_OFS_LO 8'h15
`define IDX_CH2_GAIN_HI 8'h16
`define IDX_FIRST 8'h10
`define NUM_REGS 7
// ==========================================================================
// reset values
`define RST_ZERO 16'h0000
`define RST_GAIN_HI 16'h8000
// ==========================================================================
// field layout
`define LO_FIELD_MSB 15
`define LO_FIELD_LSB 8
`define PHASE_MSB 15
`define PHASE_LSB 6
`define DCOFF_BIT 2
`define MUX_MSB 1
`define MUX_LSB 0
// writable bits of each register kind
`define MASK_FULL 16'hffff
`define MASK_LOW_REG 16'hff00
`define MASK_CONFIG 16'hffc7
// gain multiply: unity at 800000h, so shift the product by 23
`define GAIN_SHIFT 23
`define SAT_POS 24'h7fffff
`define SAT_NEG 24'h800000
`endif

// ===== design/chan_cal_pkg.sv
// types shared by the channel calibration bank
package chan_cal_pkg;
  typedef enum logic [1:0] {
    input_pins = 2'h0,
    input_shorted = 2'h1,
    input_test_pos = 2'h2,
    input_test_neg = 2'h3
  } input_sel_t;
  typedef enum logic [2:0] {
    bus_idle = 3'h1,
    bus_resp = 3'h2,
    bus_done = 3'h4
  } bus_state_t;
endpackage

// ===== design/reg_store.sv
// register storage with per-register writable mask and registered read port
`timescale 1ns/100ps
`include "chan_cal_cfg.svh"
module reg_store #(
  parameter int NREGS = `NUM_REGS,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_be,
  // read port
  input wire logic [AW-1:0] rd_idx,
  output logic [15:0] rd_data,
  // all values for the datapath
  output logic [NREGS*16-1:0] all_regs
);
  function automatic logic [15:0] wmask(input int i);
    case (i)
      0, 2, 5: wmask = `MASK_LOW_REG;
      3: wmask = `MASK_CONFIG;
      default: wmask = `MASK_FULL;
    endcase
  endfunction
  function automatic logic [15:0] rstval(input int i);
    if (i == 1 || i == 6) begin
      rstval = `RST_GAIN_HI;
    end else begin
      rstval = `RST_ZERO;
    end
  endfunction
  logic [15:0] mem_r [NREGS];
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  logic [15:0] bemask;
  assign bemask = {{8{wr_be[1]}}, {8{wr_be[0]}}};
  genvar g;
  generate
    for (g = 0; g < NREGS; g++) begin : gen_reg
      logic [15:0] nxt;
      always_comb begin
        nxt = mem_r[g];
        if (wr_en && (wr_idx == AW'(g))) begin
          nxt = (mem_r[g] & ~(wmask(g) & bemask)) | (wr_data & wmask(g) & bemask);
        end
      end
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          mem_r[g] <= rstval(g);
        end else begin
          mem_r[g] <= nxt;
        end
      end
      assign all_regs[g*16 +: 16] = mem_r[g];
    end
  endgenerate
  always_comb begin
    rd_data_nxt = 16'h0000;
    if (int'(rd_idx) < NREGS) begin
      rd_data_nxt = mem_r[rd_idx];
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end
  assign rd_data = rd_data_r;
endmodule

// ===== design/cal_apply.sv
// applies 24-bit offset and gain correction to one channel's result
`timescale 1ns/100ps
`include "chan_cal_cfg.svh"
module cal_apply (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // raw sample
  input wire logic sample_valid,
  input wire logic [23:0] sample_in,
  // correction words
  input wire logic [23:0] offset_word,
  input wire logic [23:0] gain_word,
  // corrected sample
  output logic result_valid,
  output logic [23:0] result_out
);
  logic signed [25:0] sum;
  logic signed [50:0] prod;
  logic signed [50:0] scaled;
  logic [23:0] res_nxt;
  logic [23:0] res_r;
  logic vld_r;
  // offset first, then gain, with saturation so a large trim cannot wrap
  always_comb begin
    sum = 26'(signed'(sample_in)) + 26'(signed'(offset_word));
    prod = 51'(sum) * 51'(signed'({1'b0, gain_word}));
    scaled = prod >>> `GAIN_SHIFT;
    if (scaled > 51'sd8388607) begin
      res_nxt = `SAT_POS;
    end else if (scaled < -51'sd8388608) begin
      res_nxt = `SAT_NEG;
    end else begin
      res_nxt = scaled[23:0];
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      res_r <= 24'h000000;
      vld_r <= 1'b0;
    end else begin
      vld_r <= sample_valid;
      if (sample_valid) begin
        res_r <= res_nxt;
      end
    end
  end
  assign result_valid = vld_r;
  assign result_out = res_r;
endmodule

// ===== design/channel_cal_config_regs.sv
// avalon register bank holding channel 1 and 2 calibration, less ch1 offset high and ch2 gain low, and channel 2 configuration
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "chan_cal_cfg.svh"
module channel_cal_config_regs
  import chan_cal_pkg::*;
#(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // avalon-mm slave, word address
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // channel 1 offset high bits from the neighbouring block
  input wire logic [15:0] chan1_offset_high_bits,
  // raw samples
  input wire logic ch1_sample_valid,
  input wire logic [23:0] ch1_sample,
  input wire logic ch2_sample_valid,
  input wire logic [23:0] ch2_sample,
  // corrected samples
  output logic ch1_result_valid,
  output logic [23:0] ch1_result,
  output logic ch2_result_valid,
  output logic [23:0] ch2_result,
  // channel 2 controls for the front end and filter
  input wire logic global_dc_filter_setting,
  output logic [9:0] chan2_phase_delay,
  output logic chan2_dc_filter_off,
  output logic chan2_dc_filter_active,
  output input_sel_t chan2_input_select,
  // channel 2 gain low bits from the neighbouring block
  input wire logic [7:0] chan2_gain_low_bits
);
  // ==========================================================================
  // bus front end
  bus_state_t state_r, state_nxt;
  logic hit;
  logic wr_en;
  logic [2:0] idx;
  logic [1:0] resp_r, resp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] store_rd;
  logic [7*16-1:0] regs;
  function automatic logic in_map(input logic [AW-1:0] a);
    in_map = (a >= AW'(`IDX_FIRST)) && (a < AW'(`IDX_FIRST + `NUM_REGS));
  endfunction
  assign hit = in_map(avs_address);
  assign idx = 3'(avs_address - AW'(`IDX_FIRST));
  // writes land on the idle edge; a read takes one extra cycle for the store
  assign wr_en = (state_r == bus_idle) && avs_write && hit;
  always_comb begin
    state_nxt = state_r;
    resp_nxt = resp_r;
    rdata_nxt = rdata_r;
    case (state_r)
      bus_idle: begin
        if (avs_read || avs_write) begin
          state_nxt = bus_resp;
          resp_nxt = hit ? 2'h0 : 2'h3;
        end
      end
      bus_resp: begin
        state_nxt = bus_done;
        rdata_nxt = (avs_read && hit) ? {16'h0000, store_rd} : 32'h00000000;
      end
      bus_done: begin
        state_nxt = bus_idle;
      end
      default: begin
        state_nxt = bus_idle;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= bus_idle;
      resp_r <= 2'h0;
      rdata_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      resp_r <= resp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  always_comb begin
    avs_waitrequest = (state_r != bus_done);
    avs_readdata = rdata_r;
    avs_response = resp_r;
  end
  // ==========================================================================
  // storage
  reg_store #(.NREGS(`NUM_REGS), .AW(3)) u_store (
    .mclk(mclk),
    .arst_n(arst_n),
    .wr_en(wr_en),
    .wr_idx(idx),
    .wr_data(avs_writedata[15:0]),
    .wr_be(avs_byteenable[1:0]),
    .rd_idx(idx),
    .rd_data(store_rd),
    .all_regs(regs)
  );
  logic [15:0] r_c1_olo, r_c1_ghi, r_c1_glo, r_c2_cfg, r_c2_ohi, r_c2_olo, r_c2_ghi;
  assign r_c1_olo = regs[0*16 +: 16];
  assign r_c1_ghi = regs[1*16 +: 16];
  assign r_c1_glo = regs[2*16 +: 16];
  assign r_c2_cfg = regs[3*16 +: 16];
  assign r_c2_ohi = regs[4*16 +: 16];
  assign r_c2_olo = regs[5*16 +: 16];
  assign r_c2_ghi = regs[6*16 +: 16];
  // ==========================================================================
  // correction words
  logic [23:0] c1_ofs, c1_gain, c2_ofs, c2_gain;
  assign c1_ofs = {chan1_offset_high_bits, r_c1_olo[`LO_FIELD_MSB:`LO_FIELD_LSB]};
  assign c1_gain = {r_c1_ghi, r_c1_glo[`LO_FIELD_MSB:`LO_FIELD_LSB]};
  assign c2_ofs = {r_c2_ohi, r_c2_olo[`LO_FIELD_MSB:`LO_FIELD_LSB]};
  assign c2_gain = {r_c2_ghi, chan2_gain_low_bits};
  cal_apply u_ch1 (
    .mclk(mclk),
    .arst_n(arst_n),
    .sample_valid(ch1_sample_valid),
    .sample_in(ch1_sample),
    .offset_word(c1_ofs),
    .gain_word(c1_gain),
    .result_valid(ch1_result_valid),
    .result_out(ch1_result)
  );
  cal_apply u_ch2 (
    .mclk(mclk),
    .arst_n(arst_n),
    .sample_valid(ch2_sample_valid),
    .sample_in(ch2_sample),
    .offset_word(c2_ofs),
    .gain_word(c2_gain),
    .result_valid(ch2_result_valid),
    .result_out(ch2_result)
  );
  // ==========================================================================
  // channel 2 configuration fields
  always_comb begin
    chan2_phase_delay = r_c2_cfg[`PHASE_MSB:`PHASE_LSB];
    chan2_dc_filter_off = r_c2_cfg[`DCOFF_BIT];
    chan2_dc_filter_active = global_dc_filter_setting && !r_c2_cfg[`DCOFF_BIT];
    chan2_input_select = input_sel_t'(r_c2_cfg[`MUX_MSB:`MUX_LSB]);
  end
  // ==========================================================================
  // checks
  gain_reset_a: assert property (@(posedge mclk) $rose(arst_n) |->
    r_c1_ghi == `RST_GAIN_HI && r_c2_ghi == `RST_GAIN_HI)
    else $error("gain high not at reset value");
  zero_reset_a: assert property (@(posedge mclk) $rose(arst_n) |->
    r_c2_cfg == `RST_ZERO && r_c2_ohi == `RST_ZERO && r_c1_olo == `RST_ZERO)
    else $error("zero registers not cleared");
  low_rsvd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    r_c1_olo[7:0] == 8'h00 && r_c1_glo[7:0] == 8'h00 && r_c2_olo[7:0] == 8'h00)
    else $error("reserved low byte set");
  cfg_rsvd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    r_c2_cfg[5:3] == 3'h0)
    else $error("config reserved bits set");
  ofs_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_en && idx == 3'h4 && avs_byteenable[1:0] == 2'h3 |=>
    c2_ofs[23:8] == $past(avs_writedata[15:0]))
    else $error("offset high write lost");
  olo_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_en && idx == 3'h5 && avs_byteenable[1] |=>
    c2_ofs[7:0] == $past(avs_writedata[15:8]))
    else $error("offset low write lost");
  glo_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_en && idx == 3'h2 && avs_byteenable[1] |=>
    c1_gain[7:0] == $past(avs_writedata[15:8]))
    else $error("gain low write lost");
  ghi_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_en && idx == 3'h1 && avs_byteenable[1:0] == 2'h3 |=>
    c1_gain[23:8] == $past(avs_writedata[15:0]))
    else $error("gain high write lost");
  phase_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_en && idx == 3'h3 && avs_byteenable[1:0] == 2'h3 |=>
    chan2_phase_delay == $past(avs_writedata[15:6]) &&
    chan2_input_select == $past(avs_writedata[1:0]))
    else $error("config write lost");
  dc_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    chan2_dc_filter_off |-> !chan2_dc_filter_active)
    else $error("dc filter not disabled");
  unity_gain_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ch2_sample_valid && c2_gain == 24'h800000 && c2_ofs == 24'h000000 && $stable(c2_gain) |=>
    ch2_result == $past(ch2_sample))
    else $error("unity gain not transparent");
  answer_bound_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_r == bus_idle && (avs_read || avs_write) |-> ##2 !avs_waitrequest)
    else $error("bus answer late");
  read_cov: cover property (@(posedge mclk) avs_read && !avs_waitrequest && hit);
  write_cov: cover property (@(posedge mclk) wr_en);
  unmapped_cov: cover property (@(posedge mclk) !avs_waitrequest && avs_response == 2'h3);
  test_sig_cov: cover property (@(posedge mclk) chan2_input_select == input_test_neg);
endmodule

// ===== testbench/channel_cal_config_regs_tb.sv
// randomised self-checking bench for the channel calibration register bank
`timescale 1ns/100ps
`include "chan_cal_cfg.svh"
module channel_cal_config_regs_tb import chan_cal_pkg::*;;
  // ==========================================================================
  // stimulus and observed signals
  logic mclk;
  logic arst_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [15:0] chan1_offset_high_bits;
  logic ch1_sample_valid;
  logic [23:0] ch1_sample;
  logic ch2_sample_valid;
  logic [23:0] ch2_sample;
  logic ch1_result_valid;
  logic [23:0] ch1_result;
  logic ch2_result_valid;
  logic [23:0] ch2_result;
  logic global_dc_filter_setting;
  logic [9:0] chan2_phase_delay;
  logic chan2_dc_filter_off;
  logic chan2_dc_filter_active;
  input_sel_t chan2_input_select;
  logic [7:0] chan2_gain_low_bits;
  int fails;
  int checks_done;
  int cycles;
  logic [31:0] seed;
  logic [31:0] rd_q;
  logic [1:0] rsp_q;
  logic [15:0] w [7];
  logic [15:0] masks [7] = '{16'hff00, 16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00, 16'hffff};
  logic [15:0] rstv [7] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
  channel_cal_config_regs #(.AW(8)) u_channel_cal_config_regs (
    .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .chan1_offset_high_bits(chan1_offset_high_bits),
    .ch1_sample_valid(ch1_sample_valid), .ch1_sample(ch1_sample),
    .ch2_sample_valid(ch2_sample_valid), .ch2_sample(ch2_sample),
    .ch1_result_valid(ch1_result_valid), .ch1_result(ch1_result),
    .ch2_result_valid(ch2_result_valid), .ch2_result(ch2_result),
    .global_dc_filter_setting(global_dc_filter_setting),
    .chan2_phase_delay(chan2_phase_delay), .chan2_dc_filter_off(chan2_dc_filter_off),
    .chan2_dc_filter_active(chan2_dc_filter_active),
    .chan2_input_select(chan2_input_select), .chan2_gain_low_bits(chan2_gain_low_bits));
  // ==========================================================================
  // helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // signed sum times unsigned gain, unity at 800000h, clamped to 24-bit signed
  function logic [23:0] cal(input logic [23:0] s, input logic [23:0] o, input logic [23:0] g);
    longint p;
    p = (longint'(signed'(s)) + longint'(signed'(o))) * longint'({40'h0, g});
    p = p >>> 23;
    if (p > 64'sh7fffff) return 24'h7fffff;
    if (p < -64'sh800000) return 24'h800000;
    return p[23:0];
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out();
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one avalon transfer; holds the request until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= {2'b00, be};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd_q = avs_readdata;
    rsp_q = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // ==========================================================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 20000) begin
      fails++;
      close_out();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] t;
    logic [23:0] s1;
    logic [23:0] s2;
    seed = 32'd75;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    arst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    chan1_offset_high_bits = 16'h0000;
    ch1_sample_valid = 1'b0;
    ch1_sample = 24'h000000;
    ch2_sample_valid = 1'b0;
    ch2_sample = 24'h000000;
    global_dc_filter_setting = 1'b0;
    chan2_gain_low_bits = 8'h00;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, `IDX_FIRST + 8'(i), 16'h0000, 2'b11);
      chk(rd_q, {16'h0000, rstv[i]});
      chk({30'h0, rsp_q}, 32'h0);
    end
    // all-ones first, then random, each written and read back to back
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 7; i++) begin
        t = (r == 0) ? 32'hffff : rnd();
        w[i] = t[15:0] & masks[i];
        bus(1'b1, `IDX_FIRST + 8'(i), t[15:0], 2'b11);
        bus(1'b0, `IDX_FIRST + 8'(i), 16'h0000, 2'b11);
        chk(rd_q, {16'h0000, w[i]});
      end
    end
    // upper lane only must leave the low byte alone
    bus(1'b1, `IDX_CH1_GAIN_HI, 16'h5aa5, 2'b10);
    bus(1'b0, `IDX_CH1_GAIN_HI, 16'h0000, 2'b11);
    chk(rd_q, {16'h0000, 8'h5a, w[1][7:0]});
    // reset in mid-run must bring every register back to its reset value
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, `IDX_FIRST + 8'(i), 16'h0000, 2'b11);
      chk(rd_q, {16'h0000, rstv[i]});
    end
    // every input code, both dc filter settings
    for (int m = 0; m < 4; m++) begin
      t = rnd();
      global_dc_filter_setting <= m[1] ^ m[0];
      bus(1'b1, `IDX_CH2_CONFIG, {t[9:0], 3'b111, m[0], m[1:0]}, 2'b11);
      @(posedge mclk);
      chk({22'h0, chan2_phase_delay}, {22'h0, t[9:0]});
      chk({31'h0, chan2_dc_filter_off}, {31'h0, m[0]});
      chk({31'h0, chan2_dc_filter_active}, {31'h0, (m[1] ^ m[0]) & ~m[0]});
      chk({30'h0, 2'(chan2_input_select)}, {30'h0, m[1:0]});
    end
    // unmapped places on both sides of the bank
    bus(1'b1, 8'h20, 16'hffff, 2'b11);
    chk({30'h0, rsp_q}, 32'h3);
    bus(1'b0, 8'h20, 16'h0000, 2'b11);
    chk({14'h0, rsp_q, rd_q[15:0]}, {14'h0, 2'h3, 16'h0000});
    bus(1'b0, 8'h0f, 16'h0000, 2'b11);
    chk({14'h0, rsp_q, rd_q[15:0]}, {14'h0, 2'h3, 16'h0000});
    // datapath: unity gain, saturation, then random; offsets kept small and positive
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 7; i++) begin
        t = rnd();
        w[i] = t[15:0] & masks[i];
        if (i == 4) w[i] = {9'h000, t[6:0]};
        if ((i == 4 || i == 5) && k == 0) w[i] = 16'h0000;
        if (i == 1 || i == 6) w[i] = (k == 0) ? 16'h8000 : (k == 1) ? 16'hffff : t[31:16];
        if (i == 2 && k < 2) w[i] = (k == 0) ? 16'h0000 : 16'hff00;
        bus(1'b1, `IDX_FIRST + 8'(i), w[i], 2'b11);
      end
      t = rnd();
      chan1_offset_high_bits <= {9'h000, t[6:0]};
      chan2_gain_low_bits <= (k == 0) ? 8'h00 : (k == 1) ? 8'hff : t[15:8];
      t = rnd();
      s1 = (k == 1) ? 24'h3fffff : {3'b000, t[20:0]};
      t = rnd();
      s2 = (k == 1) ? 24'h3fffff : {3'b000, t[20:0]};
      @(posedge mclk);
      ch1_sample_valid <= 1'b1;
      ch2_sample_valid <= 1'b1;
      ch1_sample <= s1;
      ch2_sample <= s2;
      @(posedge mclk);
      ch1_sample_valid <= 1'b0;
      ch2_sample_valid <= 1'b0;
      @(posedge mclk);
      chk({31'h0, ch1_result_valid}, 32'h1);
      chk({31'h0, ch2_result_valid}, 32'h1);
      chk({8'h0, ch1_result}, {8'h0, cal(s1, {chan1_offset_high_bits, w[0][15:8]},
        {w[1], w[2][15:8]})});
      chk({8'h0, ch2_result}, {8'h0, cal(s2, {w[4], w[5][15:8]},
        {w[6], chan2_gain_low_bits})});
    end
    close_out();
  end
endmodule
